/* modbus_poller.sv */
// Purpose: gateway-side reader that polls the register image word by word
// Assumes: a read is taken on the rising edge with rd_en high
// Notes: idle address is inverted so stale values never look valid
`timescale 1ns/100ps
module modbus_poller (
   // clock
   input wire logic         clk_sys,
   // read port
   output logic             rd_en,
   output logic [15:0]      rd_addr,
   input wire logic [15:0]  rd_data,
   input wire logic         rd_valid,
   input wire logic         rd_hit
);
   initial begin
      rd_en = 1'b0;
      rd_addr = 16'hffff;
   end
   task automatic read_word(input logic [15:0] a, output logic [15:0] d, output logic h);
      @(negedge clk_sys);
      rd_en = 1'b1;
      rd_addr = a;
      @(negedge clk_sys);
      rd_en = 1'b0;
      rd_addr = ~a;
      d = rd_valid ? rd_data : 16'hxxxx;
      h = rd_hit;
   endtask
endmodule // modbus_poller

/* testbench.sv */
// Purpose: reads the whole image through the poller across fault cases
// Assumes: short check-in and minute counts for simulation
// Notes: reset image reads probe J and status 0
`timescale 1ns/100ps
module testbench
   import thermo_regs_pkg::*;
;
   logic clk_sys = 1'b0, srst = 1'b1, sample_valid = 1'b0;
   logic rd_en, rd_valid, rd_hit, image_refresh;
   logic [15:0] rd_addr, rd_data;
   sensor_sample_t sample = '0;
   system_info_t sys_info = '{16'h3, 16'h4, 16'h5, 16'h6, 32'h12345678, 16'h7, 16'hffb5, 16'h2ee0, 1'b0};
   int fails = 0, compares = 0, i;
   logic [15:0] e [12];
   always #20 clk_sys = ~clk_sys;
   thermo_node_modbus_register_map #(.checkin_count(20), .minute_count(10), .timeout_reload(16'h5),
      .cached_count(16'h30)) dut_u (.*);
   modbus_poller mb_u (.*);
   task automatic chk(input logic [15:0] n, e, s);
      compares++;
      if (s !== e) begin
         fails++;
         $display("Error reg %h expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] x, input logic h = 1'b1);
      logic [15:0] d;
      logic g;
      mb_u.read_word(a, d, g);
      chk(a, x, d);
      chk(a, {15'h0, h}, {15'h0, g});
   endtask
   task automatic push(input logic [2:0] f);
      @(negedge clk_sys);
      sample = '{1'b1, 16'hffce, 16'h00c8, 16'h00e6, 16'h02a8, 32'hc0a00000, 32'h41b80000, f[2], f[1], f[0]};
      sample_valid = 1'b1;
      @(negedge clk_sys);
      sample_valid = 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic image_ok;
      e = '{16'h2, 16'hffce, 16'h00c8, 16'h0, 16'h0, 16'h0,
            16'hc0a0, 16'h0, 16'h00e6, 16'h02a8, 16'h41b8, 16'h0};
      for (i = 0; i < 12; i++) rd(off_probe_type_code + 16'(i), e[i]);
   endtask
   task automatic stop_test;
      if (fails == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge clk_sys);
      srst = 1'b0;
      rd(off_probe_type_code, probe_kind_j);
      rd(off_system_status_code, status_no_error);
      push(3'b000);
      rd(off_timeout_minutes_left, 16'h5);
      image_ok;
      e = '{16'h3, 16'h4, 16'h5, 16'h6, 16'h1234, 16'h5678, 16'h7, 16'hffb5, 16'h2ee0, 16'h0, 16'h30, 16'h0};
      for (i = 0; i < 9; i++) rd(off_mainboard_rev_major + 16'(i), e[i]);
      rd(off_cached_register_count, 16'h30);
      rd(off_remote_device_kind, device_kind_default);
      rd(16'h0000, 16'h0, 1'b0);
      rd(16'h03f4, 16'h0, 1'b0);
      repeat (80) @(negedge clk_sys);
      rd(off_timeout_minutes_left, 16'h0);
      for (int f = 0; f < 3; f++) begin
         push(3'b100 >> f);
         if (f == 0) rd(off_timeout_minutes_left, 16'h5);
         e = '{16'h2, 16'h8000, 16'h8000, 16'h0, 16'h0, 16'h0, 16'h7f80, 16'h0, 16'h8000, 16'h8000, 16'h7f80, 16'h0};
         e[3 + f] = 16'h1;
         for (i = 0; i < 12; i++) rd(off_probe_type_code + 16'(i), e[i]);
         rd(off_system_status_code, status_read_failed);
      end
      sys_info.low_power = 1'b1;
      repeat (25) @(negedge clk_sys);
      rd(off_system_status_code, 16'h3);
      push(3'b000);
      rd(off_system_status_code, status_low_power);
      image_ok;
      // mid-run reset must bring back the empty image and a full timeout
      srst = 1'b1;
      repeat (2) @(negedge clk_sys);
      srst = 1'b0;
      rd(off_probe_type_code, probe_kind_j);
      rd(off_system_status_code, status_no_error);
      rd(off_timeout_minutes_left, 16'h5);
      stop_test;
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      stop_test;
   end
endmodule // testbench

/* thermo_map_chk.sv */
// Purpose: port-level checks of the node register image
// Assumes: one clk_sys domain, srst synchronous active high
// Notes: bound to every instance of the register map
`timescale 1ns/100ps
module thermo_map_chk
   import thermo_regs_pkg::*;
#(
   parameter int checkin_count = 20
) (
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic        sample_valid,
   input wire logic        rd_en,
   input wire logic [15:0] rd_addr,
   input wire logic [15:0] rd_data,
   input wire logic        rd_valid,
   input wire logic        rd_hit,
   input wire logic        image_refresh
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // cycles since the last snapshot, capped so it cannot wrap
   int gap;
   always_ff @(posedge clk_sys) begin
      if (srst || image_refresh) gap <= 0;
      else if (gap < 1000) gap <= gap + 1;
   end
   sequence s_read(logic [15:0] a);
      rd_en && rd_addr == a;
   endsequence
   a_read_answered: assert property (rd_en |=> rd_valid)
      else $error("read not answered next cycle");
   a_no_stray_valid: assert property (!rd_en |=> !rd_valid)
      else $error("read valid without request");
   a_type_code: assert property (s_read(off_probe_type_code)
      |=> rd_hit && rd_data inside {16'h0001, 16'h0002})
      else $error("probe type code out of range");
   a_flag_words: assert property (rd_en && rd_addr inside {16'h03eb, 16'h03ec, 16'h03ed}
      |=> rd_data[15:1] == 15'h0)
      else $error("fault flag word not 0 or 1");
   a_status_code: assert property (s_read(off_system_status_code) |=> rd_hit && rd_data[15:2] == 14'h0)
      else $error("status code above 3");
   a_unmapped_zero: assert property (s_read(16'h0000) |=> !rd_hit && rd_data == 16'h0000)
      else $error("unmapped read not zero");
   a_sample_refresh: assert property (sample_valid |=> image_refresh)
      else $error("new sample did not refresh image");
   a_refresh_period: assert property (gap <= checkin_count + 1)
      else $error("check-in refresh overdue");
endmodule // thermo_map_chk

bind thermo_node_modbus_register_map thermo_map_chk #(.checkin_count(checkin_count)) chk_u (
   .clk_sys(clk_sys), .srst(srst), .sample_valid(sample_valid), .rd_en(rd_en), .rd_addr(rd_addr),
   .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit), .image_refresh(image_refresh));

/* thermo_node_modbus_register_map.sv */
// Purpose: read-only register image of a temperature node, read by word offset
// Assumes: inputs come from logic on clk_sys; read data is registered
// Notes: the image is refreshed once per check-in interval or on new data
`timescale 1ns/100ps
// How it works
// - offset 1000 reports 1 for J probe, 2 for K probe
// - offset 1001 holds probe temperature in signed tenths of Celsius
// - offset 1002 holds reference temperature in tenths of Celsius
// - offsets 1008/1009 hold probe and reference in tenths of Fahrenheit
// - probe Celsius float: high half 1006, low half 1007
// - probe Fahrenheit float: high half 1010, low half 1011
// - offset 1003 flags missing interface board
// - offset 1004 flags probe shorted to ground
// - offset 1005 flags open probe
// - any fault forces integer temperature words to 32768
// - any fault forces float pairs to positive infinity
// - status: 0 none, 1 low power, 2 failed read, 3 both
// - probe or board faults show as failed read in status
// - system words are 16 bits under the same slave identifier
// - revisions of mainboard and radio at 9987 through 9990
// - node address high at 9991, low radio identifier at 9992
// - offset 9994 reports last packet signal strength
// - offset 9995 reports supply millivolts unsigned
// - offset 9996 counts minutes to timeout, restarting on new data
// - offset 9997 reports number of cached registers
// - image refreshed once per check-in interval and on every new sample
module thermo_node_modbus_register_map
   import thermo_regs_pkg::*;
#(
   parameter int          checkin_count  = checkin_cycles,
   parameter int          minute_count   = minute_cycles,
   parameter logic [15:0] timeout_reload = timeout_minutes_default,
   parameter logic [15:0] cached_count   = cached_count_default,
   parameter logic [15:0] device_kind    = device_kind_default
) (
   // clock and reset
   input  wire logic           clk_sys,
   input  wire logic           srst,
   // sample and system sources
   input  wire sensor_sample_t sample,
   input  wire logic           sample_valid,
   input  wire system_info_t   sys_info,
   // register read port
   input  wire logic           rd_en,
   input  wire logic [15:0]    rd_addr,
   output logic [15:0]         rd_data,
   output logic                rd_valid,
   output logic                rd_hit,
   // refresh event
   output logic                image_refresh
);

   sensor_sample_t latest;
   sensor_sample_t image;
   system_info_t   sys_image;
   logic [31:0]    checkin_cnt;
   logic [31:0]    minute_cnt;
   logic [15:0]    minutes_left;
   logic           any_fault;
   logic [15:0]    status_word;
   logic [15:0]    next_rd_data;
   logic           next_rd_hit;

   // newest sample kept until the next check-in snapshot
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         latest <= '0;
      end else if (sample_valid) begin
         latest <= sample;
      end
   end

   // check-in timer; a fresh sample also forces a check-in
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         checkin_cnt   <= '0;
         image_refresh <= 1'b0;
      end else if (sample_valid || checkin_cnt == 32'(checkin_count - 1)) begin
         checkin_cnt   <= '0;
         image_refresh <= 1'b1;
      end else begin
         checkin_cnt   <= checkin_cnt + 32'd1;
         image_refresh <= 1'b0;
      end
   end

   // snapshot so a master never reads a half-updated float pair
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         image     <= '0;
         sys_image <= '0;
      end else if (image_refresh) begin
         image     <= latest;
         sys_image <= sys_info;
      end
   end

   // timeout minute countdown, floors at zero
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         minute_cnt   <= '0;
         minutes_left <= timeout_reload;
      end else if (sample_valid) begin
         minute_cnt   <= '0;
         minutes_left <= timeout_reload;
      end else if (minute_cnt == 32'(minute_count - 1)) begin
         minute_cnt <= '0;
         if (minutes_left != 16'h0000) begin
            minutes_left <= minutes_left - 16'h0001;
         end
      end else begin
         minute_cnt <= minute_cnt + 32'd1;
      end
   end

   assign any_fault = image.board_missing | image.short_ground | image.probe_open;
   assign status_word = (sys_image.low_power ? status_low_power : status_no_error)
                      | (any_fault ? status_read_failed : status_no_error);

   // read decode; unmapped offsets answer zero with rd_hit low
   always_comb begin
      next_rd_data = unmapped_word;
      next_rd_hit  = 1'b1;
      unique case (rd_addr)
         off_probe_type_code:       next_rd_data = image.probe_is_k ? probe_kind_k : probe_kind_j;
         off_probe_temp_tenth_c:    next_rd_data = any_fault ? fail_high_int : image.probe_tenth_c;
         off_ref_temp_tenth_c:      next_rd_data = any_fault ? fail_high_int : image.ref_tenth_c;
         off_fault_board_missing:   next_rd_data = {15'h0000, image.board_missing};
         off_fault_short_ground:    next_rd_data = {15'h0000, image.short_ground};
         off_fault_probe_open:      next_rd_data = {15'h0000, image.probe_open};
         off_probe_temp_c_float_hi:
            next_rd_data = any_fault ? float_pos_inf[31:16] : image.probe_c_float[31:16];
         off_probe_temp_c_float_lo:
            next_rd_data = any_fault ? float_pos_inf[15:0] : image.probe_c_float[15:0];
         off_probe_temp_tenth_f:    next_rd_data = any_fault ? fail_high_int : image.probe_tenth_f;
         off_ref_temp_tenth_f:      next_rd_data = any_fault ? fail_high_int : image.ref_tenth_f;
         off_probe_temp_f_float_hi:
            next_rd_data = any_fault ? float_pos_inf[31:16] : image.probe_f_float[31:16];
         off_probe_temp_f_float_lo:
            next_rd_data = any_fault ? float_pos_inf[15:0] : image.probe_f_float[15:0];
         off_system_status_code:    next_rd_data = status_word;
         off_mainboard_rev_major:   next_rd_data = sys_image.main_major;
         off_mainboard_rev_minor:   next_rd_data = sys_image.main_minor;
         off_radio_rev_major:       next_rd_data = sys_image.radio_major;
         off_radio_rev_minor:       next_rd_data = sys_image.radio_minor;
         off_node_address_hi:       next_rd_data = sys_image.node_address[31:16];
         off_node_address_lo:       next_rd_data = sys_image.node_address[15:0];
         off_slave_id_readback:     next_rd_data = sys_image.slave_id;
         off_last_packet_signal:    next_rd_data = sys_image.signal_strength;
         off_supply_millivolts:     next_rd_data = sys_image.supply_mv;
         off_timeout_minutes_left:  next_rd_data = minutes_left;
         off_cached_register_count: next_rd_data = cached_count;
         off_remote_device_kind:    next_rd_data = device_kind;
         default:                   next_rd_hit  = 1'b0;
      endcase
   end

   // registered read answer, one cycle after rd_en
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_data  <= reset_word;
         rd_valid <= 1'b0;
         rd_hit   <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         if (rd_en) begin
            rd_data <= next_rd_data;
            rd_hit  <= next_rd_hit;
         end
      end
   end

endmodule // thermo_node_modbus_register_map

/* thermo_regs_pkg.sv */
// Purpose: constants and carrier types for the node register image
// Assumes: 16-bit word registers addressed by Modbus word offset
// Notes: identity value below is arbitrary
package thermo_regs_pkg;
   localparam logic [15:0] off_probe_type_code         = 16'h03e8;
   localparam logic [15:0] off_probe_temp_tenth_c      = 16'h03e9;
   localparam logic [15:0] off_ref_temp_tenth_c        = 16'h03ea;
   localparam logic [15:0] off_fault_board_missing     = 16'h03eb;
   localparam logic [15:0] off_fault_short_ground      = 16'h03ec;
   localparam logic [15:0] off_fault_probe_open        = 16'h03ed;
   localparam logic [15:0] off_probe_temp_c_float_hi   = 16'h03ee;
   localparam logic [15:0] off_probe_temp_c_float_lo   = 16'h03ef;
   localparam logic [15:0] off_probe_temp_tenth_f      = 16'h03f0;
   localparam logic [15:0] off_ref_temp_tenth_f        = 16'h03f1;
   localparam logic [15:0] off_probe_temp_f_float_hi   = 16'h03f2;
   localparam logic [15:0] off_probe_temp_f_float_lo   = 16'h03f3;
   localparam logic [15:0] off_system_status_code      = 16'h2702;
   localparam logic [15:0] off_mainboard_rev_major     = 16'h2703;
   localparam logic [15:0] off_mainboard_rev_minor     = 16'h2704;
   localparam logic [15:0] off_radio_rev_major         = 16'h2705;
   localparam logic [15:0] off_radio_rev_minor         = 16'h2706;
   localparam logic [15:0] off_node_address_hi         = 16'h2707;
   localparam logic [15:0] off_node_address_lo         = 16'h2708;
   localparam logic [15:0] off_slave_id_readback       = 16'h2709;
   localparam logic [15:0] off_last_packet_signal      = 16'h270a;
   localparam logic [15:0] off_supply_millivolts       = 16'h270b;
   localparam logic [15:0] off_timeout_minutes_left    = 16'h270c;
   localparam logic [15:0] off_cached_register_count   = 16'h270d;
   localparam logic [15:0] off_remote_device_kind      = 16'h270e;

   localparam logic [15:0] probe_kind_j        = 16'h0001;
   localparam logic [15:0] probe_kind_k        = 16'h0002;
   localparam logic [15:0] fail_high_int       = 16'h8000;
   localparam logic [31:0] float_pos_inf       = 32'h7f800000;
   localparam logic [15:0] status_no_error     = 16'h0000;
   localparam logic [15:0] status_low_power    = 16'h0001;
   localparam logic [15:0] status_read_failed  = 16'h0002;
   localparam logic [15:0] reset_word          = 16'h0000;
   localparam logic [15:0] unmapped_word       = 16'h0000;
   localparam logic [15:0] device_kind_default = 16'h00a5; // arbitrary value, names no real part
   localparam logic [15:0] cached_count_default = 16'h0019;

   localparam int clk_hz          = 25000000;
   localparam int checkin_seconds = 10;
   localparam int checkin_cycles  = clk_hz * checkin_seconds;
   localparam int minute_seconds  = 60;
   localparam int minute_cycles   = clk_hz * minute_seconds;
   localparam logic [15:0] timeout_minutes_default = 16'h003c;

   typedef struct packed {
      logic        probe_is_k;
      logic [15:0] probe_tenth_c;
      logic [15:0] ref_tenth_c;
      logic [15:0] probe_tenth_f;
      logic [15:0] ref_tenth_f;
      logic [31:0] probe_c_float;
      logic [31:0] probe_f_float;
      logic        board_missing;
      logic        short_ground;
      logic        probe_open;
   } sensor_sample_t;

   typedef struct packed {
      logic [15:0] main_major;
      logic [15:0] main_minor;
      logic [15:0] radio_major;
      logic [15:0] radio_minor;
      logic [31:0] node_address;
      logic [15:0] slave_id;
      logic [15:0] signal_strength;
      logic [15:0] supply_mv;
      logic        low_power;
   } system_info_t;
endpackage
